// file: hdl/power_rail_pkg.sv
package power_rail_pkg;

  // Register byte addresses on the serial interface
  localparam logic [7:0] ADDR_IO_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_CORE_CTRL = 8'h0D;
  localparam logic [7:0] ADDR_LREG_CTRL = 8'h0E;
  localparam logic [7:0] ADDR_PIN_CFG = 8'h0F;

  // Reset values before the strap pins are folded in
  localparam logic [7:0] RST_IO_CTRL = 8'h72;
  localparam logic [7:0] RST_CORE_CTRL = 8'h68;
  localparam logic [7:0] RST_LREG_CTRL = 8'h88;
  localparam logic [7:0] RST_PIN_CFG = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // io_converter_control fields
  localparam int IO_FORCED_FIXED_FREQ = 7;
  localparam int IO_UVLO_HI = 6;
  localparam int IO_UVLO_LO = 5;
  localparam int IO_KEEP_ON = 4;
  localparam int IO_LP_PIN_ON = 3;
  localparam int IO_DISCH = 2;
  localparam int IO_VSEL_HI = 1;
  localparam int IO_VSEL_LO = 0;

  // core_converter_control fields
  localparam int CORE_OFF_SLEEP = 7;
  localparam int CORE_VSEL_HI = 6;
  localparam int CORE_VSEL_LO = 4;
  localparam int CORE_SLP_HI = 3;
  localparam int CORE_SLP_LO = 2;
  localparam int CORE_VIB = 1;
  localparam int CORE_DISCH = 0;

  // linear_regulator_control fields
  localparam int LREG_B_ON = 7;
  localparam int LREG_B_SOFF = 6;
  localparam int LREG_B_VSEL_HI = 5;
  localparam int LREG_B_VSEL_LO = 4;
  localparam int LREG_A_ON = 3;
  localparam int LREG_A_SOFF = 2;
  localparam int LREG_A_VSEL_HI = 1;
  localparam int LREG_A_VSEL_LO = 0;

  // pin_event_config fields
  localparam int PIN_EDGE_HI = 7;
  localparam int PIN_EDGE_LO = 4;
  localparam int PIN_MASK_HI = 3;
  localparam int PIN_MASK_LO = 0;
  localparam int NUM_PIN_EVENTS = 4;

  // Synchronised pin vector layout
  localparam int SYNC_WIDTH = 9;
  localparam int SP_SCL = 0;
  localparam int SP_SDA = 1;
  localparam int SP_SLEEP = 2;
  localparam int SP_IO_DEF = 3;
  localparam int SP_CORE_DEF = 4;
  localparam int SP_GPIO_LO = 5;
  localparam int SP_GPIO_HI = 8;

  // Cycles after reset release until the strap synchronisers hold real levels
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam logic [1:0] STRAP_DONE = 2'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_READ_BIT = 4'h7;

  // Arbitrary neutral bus address
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h48;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR = 4'h3,
    ST_PTR_ACK = 4'h4,
    ST_WRITE = 4'h5,
    ST_WRITE_ACK = 4'h6,
    ST_READ = 4'h7,
    ST_READ_ACK = 4'h8
  } serial_state_t;

endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output var logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_syncOut;

  always_comb begin
    next_stage1 = asyncIn;
    next_syncOut = stage1;
  end

  // Only the second stage is visible to the rest of the design
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= next_stage1;
      syncOut <= next_syncOut;
    end
  end
endmodule
`default_nettype wire

// file: hdl/pin_event_detect.sv
`timescale 1ns/1ps
`default_nettype none
module pin_event_detect #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pinLevel,
  input wire logic [WIDTH-1:0] edgeSel,
  input wire logic [WIDTH-1:0] mask,
  output var logic [WIDTH-1:0] pinEvent
);
  logic [WIDTH-1:0] prevLevel;
  logic [WIDTH-1:0] next_pinEvent;
  logic [2:0] warmUp;
  logic primed;

  // Primed waits until prevLevel holds a synchronised level, so a pin idling high
  // gives no false edge after reset
  assign primed = warmUp[2];
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      assign next_pinEvent[i] = primed && !mask[i] &&
        (edgeSel[i] ? (pinLevel[i] && !prevLevel[i])
                    : (!pinLevel[i] && prevLevel[i]));
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prevLevel <= '0;
      pinEvent <= '0;
      warmUp <= 3'h0;
    end else begin
      prevLevel <= pinLevel;
      pinEvent <= next_pinEvent;
      warmUp <= {warmUp[1:0], 1'b1};
    end
  end
endmodule
`default_nettype wire

// file: hdl/power_rail_control_regs.sv
// Contract
// - Fixed-frequency bit forbids PFM on both converters
// - Two bits pick undervoltage threshold, reset 11
// - Sleep pin disables converters unless keep-on set
// - Sleep pin ignored while its function is off
// - io rail discharges only when enabled and off
// - Two bits pick io rail voltage
// - io voltage low bit taken from strap
// - Core voltage code low bit taken from strap pin
// - Core-off-in-sleep disables core rail in sleep
// - Three bits pick one of eight core voltages
// - Sleep core code is zero plus sleep field
// - Leaving sleep restores full core voltage code
// - Vibrator transistor follows its drive bit
// - Core rail discharges only when enabled and off
// - Regulator B: off, full, reduced or sleep-off
// - Regulator A: same four-state behaviour
// - Regulator B voltage codes, reset 1.8 V
// - Regulator A code 00 is adjustable, reset
// - Edge bit chooses rising or falling pin event
// - Mask bit suppresses its pin event, reset unmasked
// - Both regulators enabled, sleep-off clear after reset
// - High sleep pin requests low-power mode
`timescale 1ns/1ps
`default_nettype none
module power_rail_control_regs #(
  parameter logic [6:0] SLAVE_ADDR = power_rail_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sdaIn,
  output var logic sdaOut,
  output var logic sdaOe,
  input wire logic sleepRequestPin,
  input wire logic ioRailDefaultPin,
  input wire logic coreDefaultPin,
  input wire logic [power_rail_pkg::NUM_PIN_EVENTS-1:0] gpioPin,
  output var logic forcedFixedFreq,
  output var logic [1:0] undervoltageThresholdSel,
  output var logic ioRailEnable,
  output var logic coreRailEnable,
  output var logic ioRailDischarge,
  output var logic coreRailDischarge,
  output var logic [1:0] ioRailVoltageSel,
  output var logic [2:0] coreRailVoltageSel,
  output var logic vibratorOut,
  output var logic vibratorOe,
  output var logic regulatorAOn,
  output var logic regulatorAReduced,
  output var logic [1:0] regulatorAVoltageSel,
  output var logic regulatorBOn,
  output var logic regulatorBReduced,
  output var logic [1:0] regulatorBVoltageSel,
  output var logic [power_rail_pkg::NUM_PIN_EVENTS-1:0] pinEvent
);
  import power_rail_pkg::*;

  logic [SYNC_WIDTH-1:0] rawPins;
  logic [SYNC_WIDTH-1:0] syncPins;
  logic sclNow, sdaNow, sclPrev, sdaPrev;
  logic sclRise, sclFall, startCond, stopCond;
  logic sleepNow, lowPower;

  serial_state_t state, next_state;
  logic [3:0] bitCnt, next_bitCnt;
  logic [7:0] shiftReg, next_shiftReg;
  logic [7:0] pointer, next_pointer;
  logic sdaDrive, next_sdaDrive;
  logic bankWrite;
  logic [7:0] readData;

  logic [7:0] ioCtrl, next_ioCtrl;
  logic [7:0] coreCtrl, next_coreCtrl;
  logic [7:0] lregCtrl, next_lregCtrl;
  logic [7:0] pinCfg, next_pinCfg;
  logic [1:0] startCnt, next_startCnt;
  logic strapLoad;

  logic next_ioOn, next_coreOn;
  logic next_regAOn, next_regAReduced, next_regBOn, next_regBReduced;
  logic [2:0] next_coreVsel;

  assign rawPins = {gpioPin, coreDefaultPin, ioRailDefaultPin, sleepRequestPin, sdaIn, scl};

  pin_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn(rawPins),
    .syncOut(syncPins)
  );

  pin_event_detect #(.WIDTH(NUM_PIN_EVENTS)) u_events (
    .clk(clk),
    .rst(rst),
    .pinLevel(syncPins[SP_GPIO_HI:SP_GPIO_LO]),
    .edgeSel(pinCfg[PIN_EDGE_HI:PIN_EDGE_LO]),
    .mask(pinCfg[PIN_MASK_HI:PIN_MASK_LO]),
    .pinEvent(pinEvent)
  );

  assign sclNow = syncPins[SP_SCL];
  assign sdaNow = syncPins[SP_SDA];
  assign sleepNow = syncPins[SP_SLEEP];
  assign sclRise = sclNow && !sclPrev;
  assign sclFall = !sclNow && sclPrev;
  assign startCond = sclNow && sclPrev && sdaPrev && !sdaNow;
  assign stopCond = sclNow && sclPrev && !sdaPrev && sdaNow;
  assign sdaOut = 1'b0;
  assign sdaOe = sdaDrive;
  assign vibratorOut = 1'b0;

  // Sleep pin only counts when its low-power function is switched on
  assign lowPower = ioCtrl[IO_LP_PIN_ON] && sleepNow;

  // A data byte commits on the SCL fall that ends its eighth bit
  assign bankWrite = (state == ST_WRITE) && sclFall && (bitCnt == BITS_PER_BYTE);
  assign strapLoad = (startCnt == STRAP_SETTLE);

  always_comb begin
    case (pointer)
      ADDR_IO_CTRL: readData = ioCtrl;
      ADDR_CORE_CTRL: readData = coreCtrl;
      ADDR_LREG_CTRL: readData = lregCtrl;
      ADDR_PIN_CFG: readData = pinCfg;
      default: readData = UNMAPPED_READ;
    endcase
  end

  // Serial slave: address, pointer, then auto-incrementing data bytes
  always_comb begin
    next_state = state;
    next_bitCnt = bitCnt;
    next_shiftReg = shiftReg;
    next_pointer = pointer;
    next_sdaDrive = sdaDrive;
    if (startCond) begin
      next_state = ST_ADDR;
      next_bitCnt = 4'h0;
      next_sdaDrive = 1'b0;
    end else if (stopCond) begin
      next_state = ST_IDLE;
      next_sdaDrive = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_sdaDrive = 1'b0;
        end
        ST_ADDR, ST_PTR, ST_WRITE: begin
          if (sclRise) begin
            next_shiftReg = {shiftReg[6:0], sdaNow};
            next_bitCnt = bitCnt + 4'h1;
          end else if (sclFall && bitCnt == BITS_PER_BYTE) begin
            next_bitCnt = 4'h0;
            next_sdaDrive = 1'b1;
            if (state == ST_ADDR) begin
              if (shiftReg[7:1] == SLAVE_ADDR) begin
                next_state = ST_ADDR_ACK;
              end else begin
                next_state = ST_IDLE;
                next_sdaDrive = 1'b0;
              end
            end else if (state == ST_PTR) begin
              next_pointer = shiftReg;
              next_state = ST_PTR_ACK;
            end else begin
              next_pointer = pointer + 8'h01;
              next_state = ST_WRITE_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (sclFall) begin
            if (shiftReg[0]) begin
              next_state = ST_READ;
              next_shiftReg = readData;
              next_sdaDrive = !readData[7];
              next_pointer = pointer + 8'h01;
            end else begin
              next_state = ST_PTR;
              next_sdaDrive = 1'b0;
            end
          end
        end
        ST_PTR_ACK, ST_WRITE_ACK: begin
          if (sclFall) begin
            next_state = ST_WRITE;
            next_sdaDrive = 1'b0;
          end
        end
        ST_READ: begin
          if (sclFall) begin
            if (bitCnt == LAST_READ_BIT) begin
              next_bitCnt = 4'h0;
              next_sdaDrive = 1'b0;
              next_state = ST_READ_ACK;
            end else begin
              next_bitCnt = bitCnt + 4'h1;
              next_shiftReg = {shiftReg[6:0], 1'b0};
              next_sdaDrive = !shiftReg[6];
            end
          end
        end
        ST_READ_ACK: begin
          // A master NACK ends the read; wait for stop or repeated start
          if (sclRise && sdaNow) begin
            next_state = ST_IDLE;
          end else if (sclFall) begin
            next_state = ST_READ;
            next_shiftReg = readData;
            next_sdaDrive = !readData[7];
            next_pointer = pointer + 8'h01;
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_sdaDrive = 1'b0;
        end
      endcase
    end
  end

  // Register bank; straps land once the synchronisers hold real pin levels
  always_comb begin
    next_ioCtrl = ioCtrl;
    next_coreCtrl = coreCtrl;
    next_lregCtrl = lregCtrl;
    next_pinCfg = pinCfg;
    next_startCnt = (startCnt == STRAP_DONE) ? startCnt : startCnt + 2'h1;
    if (strapLoad) begin
      next_ioCtrl[IO_VSEL_LO] = syncPins[SP_IO_DEF];
      next_coreCtrl[CORE_VSEL_LO] = syncPins[SP_CORE_DEF];
    end
    if (bankWrite) begin
      case (pointer)
        ADDR_IO_CTRL: next_ioCtrl = shiftReg;
        ADDR_CORE_CTRL: next_coreCtrl = shiftReg;
        ADDR_LREG_CTRL: next_lregCtrl = shiftReg;
        ADDR_PIN_CFG: next_pinCfg = shiftReg;
        default: next_pinCfg = pinCfg;
      endcase
    end
  end

  // Rail control derived from the bank and the sleep request
  always_comb begin
    next_ioOn = !(lowPower && !ioCtrl[IO_KEEP_ON]);
    next_coreOn = next_ioOn && !(lowPower && coreCtrl[CORE_OFF_SLEEP]);
    // Sleep code drops the top bit; the full code returns on wake
    next_coreVsel = lowPower ? {1'b0, coreCtrl[CORE_SLP_HI:CORE_SLP_LO]}
                             : coreCtrl[CORE_VSEL_HI:CORE_VSEL_LO];
    next_regBOn = lregCtrl[LREG_B_ON] && !(lowPower && lregCtrl[LREG_B_SOFF]);
    next_regBReduced = lregCtrl[LREG_B_ON] && lowPower && !lregCtrl[LREG_B_SOFF];
    next_regAOn = lregCtrl[LREG_A_ON] && !(lowPower && lregCtrl[LREG_A_SOFF]);
    next_regAReduced = lregCtrl[LREG_A_ON] && lowPower && !lregCtrl[LREG_A_SOFF];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclPrev <= 1'b0;
      sdaPrev <= 1'b0;
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      pointer <= 8'h00;
      sdaDrive <= 1'b0;
      ioCtrl <= RST_IO_CTRL;
      coreCtrl <= RST_CORE_CTRL;
      lregCtrl <= RST_LREG_CTRL;
      pinCfg <= RST_PIN_CFG;
      startCnt <= 2'h0;
    end else begin
      sclPrev <= sclNow;
      sdaPrev <= sdaNow;
      state <= next_state;
      bitCnt <= next_bitCnt;
      shiftReg <= next_shiftReg;
      pointer <= next_pointer;
      sdaDrive <= next_sdaDrive;
      ioCtrl <= next_ioCtrl;
      coreCtrl <= next_coreCtrl;
      lregCtrl <= next_lregCtrl;
      pinCfg <= next_pinCfg;
      startCnt <= next_startCnt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      forcedFixedFreq <= RST_IO_CTRL[IO_FORCED_FIXED_FREQ];
      undervoltageThresholdSel <= RST_IO_CTRL[IO_UVLO_HI:IO_UVLO_LO];
      ioRailEnable <= 1'b1;
      coreRailEnable <= 1'b1;
      ioRailDischarge <= 1'b0;
      coreRailDischarge <= 1'b0;
      ioRailVoltageSel <= RST_IO_CTRL[IO_VSEL_HI:IO_VSEL_LO];
      coreRailVoltageSel <= RST_CORE_CTRL[CORE_VSEL_HI:CORE_VSEL_LO];
      vibratorOe <= 1'b0;
      regulatorAOn <= RST_LREG_CTRL[LREG_A_ON];
      regulatorAReduced <= 1'b0;
      regulatorAVoltageSel <= RST_LREG_CTRL[LREG_A_VSEL_HI:LREG_A_VSEL_LO];
      regulatorBOn <= RST_LREG_CTRL[LREG_B_ON];
      regulatorBReduced <= 1'b0;
      regulatorBVoltageSel <= RST_LREG_CTRL[LREG_B_VSEL_HI:LREG_B_VSEL_LO];
    end else begin
      forcedFixedFreq <= ioCtrl[IO_FORCED_FIXED_FREQ];
      undervoltageThresholdSel <= ioCtrl[IO_UVLO_HI:IO_UVLO_LO];
      ioRailEnable <= next_ioOn;
      coreRailEnable <= next_coreOn;
      ioRailDischarge <= ioCtrl[IO_DISCH] && !next_ioOn;
      coreRailDischarge <= coreCtrl[CORE_DISCH] && !next_coreOn;
      ioRailVoltageSel <= ioCtrl[IO_VSEL_HI:IO_VSEL_LO];
      coreRailVoltageSel <= next_coreVsel;
      vibratorOe <= coreCtrl[CORE_VIB];
      regulatorAOn <= next_regAOn;
      regulatorAReduced <= next_regAReduced;
      regulatorAVoltageSel <= lregCtrl[LREG_A_VSEL_HI:LREG_A_VSEL_LO];
      regulatorBOn <= next_regBOn;
      regulatorBReduced <= next_regBReduced;
      regulatorBVoltageSel <= lregCtrl[LREG_B_VSEL_HI:LREG_B_VSEL_LO];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_FIXED_FREQ: assert property (ioCtrl[IO_FORCED_FIXED_FREQ] |=> forcedFixedFreq)
    else $error("fixed-frequency output does not follow its bit");
  AST_SLEEP_OFF: assert property ((lowPower && !ioCtrl[IO_KEEP_ON]) |=>
    !ioRailEnable && !coreRailEnable)
    else $error("converters still on during sleep without keep-on");
  AST_PIN_IGNORED: assert property (!ioCtrl[IO_LP_PIN_ON] |=>
    ioRailEnable && !regulatorAReduced && !regulatorBReduced)
    else $error("sleep pin had effect while its function was off");
  AST_IO_DISCH: assert property (ioRailDischarge |->
    !ioRailEnable && $past(ioCtrl[IO_DISCH]))
    else $error("io rail discharge without cause");
  AST_CORE_OFF: assert property ((lowPower && coreCtrl[CORE_OFF_SLEEP]) |=>
    !coreRailEnable)
    else $error("core rail on in sleep with core-off set");
  AST_SLEEP_CODE: assert property (lowPower |=>
    coreRailVoltageSel == {1'b0, $past(coreCtrl[CORE_SLP_HI:CORE_SLP_LO])})
    else $error("sleep core voltage code wrong");
  AST_WAKE_CODE: assert property ($fell(lowPower) |=>
    coreRailVoltageSel == $past(coreCtrl[CORE_VSEL_HI:CORE_VSEL_LO]))
    else $error("core voltage code not restored on wake");
  AST_VIBRATOR: assert property ($rose(coreCtrl[CORE_VIB]) |=> vibratorOe ##1
    (vibratorOe == $past(coreCtrl[CORE_VIB])))
    else $error("vibrator transistor does not follow its bit");
  AST_REG_B: assert property ((lowPower && lregCtrl[LREG_B_ON] &&
    !lregCtrl[LREG_B_SOFF]) |=> regulatorBOn && regulatorBReduced)
    else $error("regulator B not reduced in sleep");
  AST_REG_A_OFF: assert property (regulatorAOn |-> $past(lregCtrl[LREG_A_ON]))
    else $error("regulator A on while disabled");
  AST_STRAP: assert property (strapLoad |=>
    ioCtrl[IO_VSEL_LO] == $past(syncPins[SP_IO_DEF]) &&
    coreCtrl[CORE_VSEL_LO] == $past(syncPins[SP_CORE_DEF]))
    else $error("strap levels not loaded");
  AST_WRITE: assert property ((bankWrite && pointer == ADDR_PIN_CFG) |=>
    pinCfg == $past(shiftReg))
    else $error("register write not applied");
  AST_MASKED: assert property (pinEvent != '0 |->
    (pinEvent & $past(pinCfg[PIN_MASK_HI:PIN_MASK_LO])) == '0)
    else $error("masked pin raised an event");
endmodule
`default_nettype wire

// file: verification/serial_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host_model #(
  parameter logic [6:0] DEV_ADDR = power_rail_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic sdaLine,
  output var logic scl,
  output var logic sdaLow
);
  import power_rail_pkg::*;
  // Bus idles high on both lines; each half period is 8 clk, twice the minimum
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Data moves only mid-way through SCL low, so it never looks like a START or STOP
  task automatic put_bit(input logic b, output logic got);
    sdaLow <= ~b;
    tick(4);
    scl <= 1'b1;
    tick(4);
    got = sdaLine;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic start_cond();
    sdaLow <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic stop_cond();
    sdaLow <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(4);
    sdaLow <= 1'b0;
    tick(8);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) put_bit(b[i], g);
    put_bit(1'b1, g);
    ack = ~g;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(1'b1, g);
      b[i] = g;
    end
    put_bit(last, g);
  endtask
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] data, output logic ok);
    logic a1, a2, a3;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, a1);
    put_byte(ptr, a2);
    put_byte(data, a3);
    stop_cond();
    ok = a1 & a2 & a3;
  endtask
  task automatic read_reg(input logic [7:0] ptr, output logic [7:0] data);
    logic a;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, a);
    put_byte(ptr, a);
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, a);
    get_byte(1'b1, data);
    stop_cond();
  endtask
endmodule
`default_nettype wire

// file: verification/power_rail_control_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module power_rail_control_regs_tb;
  import power_rail_pkg::*;
  logic clk = 1'b0;
  logic rst, scl, sdaLow, sdaOut, sdaOe, sleepRequestPin, ioRailDefaultPin, coreDefaultPin;
  logic forcedFixedFreq, ioRailEnable, coreRailEnable, ioRailDischarge, coreRailDischarge;
  logic vibratorOut, vibratorOe, regulatorAOn, regulatorAReduced, regulatorBOn, regulatorBReduced;
  logic [1:0] undervoltageThresholdSel, ioRailVoltageSel, regulatorAVoltageSel, regulatorBVoltageSel;
  logic [2:0] coreRailVoltageSel;
  logic [3:0] gpioPin, pinEvent;
  wire logic sdaLine;
  int nMismatch = 0;
  int comparisons = 0;
  // Open-drain line with pull-up: low while either party pulls it
  assign sdaLine = ~(sdaLow | sdaOe);
  always #25 clk = ~clk;
  serial_host_model host_u (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
  power_rail_control_regs dut_u (
    .clk(clk), .rst(rst), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sleepRequestPin(sleepRequestPin), .ioRailDefaultPin(ioRailDefaultPin),
    .coreDefaultPin(coreDefaultPin), .gpioPin(gpioPin), .forcedFixedFreq(forcedFixedFreq),
    .undervoltageThresholdSel(undervoltageThresholdSel), .ioRailEnable(ioRailEnable),
    .coreRailEnable(coreRailEnable), .ioRailDischarge(ioRailDischarge),
    .coreRailDischarge(coreRailDischarge), .ioRailVoltageSel(ioRailVoltageSel),
    .coreRailVoltageSel(coreRailVoltageSel), .vibratorOut(vibratorOut), .vibratorOe(vibratorOe),
    .regulatorAOn(regulatorAOn), .regulatorAReduced(regulatorAReduced),
    .regulatorAVoltageSel(regulatorAVoltageSel), .regulatorBOn(regulatorBOn),
    .regulatorBReduced(regulatorBReduced), .regulatorBVoltageSel(regulatorBVoltageSel),
    .pinEvent(pinEvent)
  );
  task automatic wrap_up();
    $display("comparisons=%0d mismatches=%0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] data);
    logic ok;
    host_u.write_reg(ptr, data, ok);
    chk({7'h0, ok}, 8'h01);
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] exp);
    logic [7:0] d;
    host_u.read_reg(ptr, d);
    chk(d, exp);
  endtask
  task automatic slp(input logic v);
    sleepRequestPin <= v;
    repeat (6) @(posedge clk);
  endtask
  function automatic logic [7:0] rails();
    return {1'b0, ioRailEnable, coreRailEnable, ioRailDischarge, coreRailDischarge,
            coreRailVoltageSel};
  endfunction
  function automatic logic [7:0] regs();
    return {regulatorBOn, regulatorBReduced, regulatorBVoltageSel, regulatorAOn,
            regulatorAReduced, regulatorAVoltageSel};
  endfunction
  task automatic t_reset();
    rd(ADDR_IO_CTRL, 8'h73);
    rd(ADDR_CORE_CTRL, 8'h68);
    rd(ADDR_LREG_CTRL, 8'h88);
    rd(ADDR_PIN_CFG, 8'h00);
    chk({1'b0, undervoltageThresholdSel, ioRailVoltageSel, coreRailVoltageSel}, 8'h7E);
    chk(regs(), 8'h88);
    rd(8'h20, UNMAPPED_READ);
    chk({6'h0, sdaOut, vibratorOut}, 8'h00);
  endtask
  task automatic t_io_fields();
    logic [1:0] c;
    logic [7:0] v;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      v = {1'b1, c, 1'b1, 1'b0, 1'b1, c};
      wr(ADDR_IO_CTRL, v);
      chk({2'b0, forcedFixedFreq, undervoltageThresholdSel, ioRailVoltageSel, ioRailDischarge},
          {2'b0, 1'b1, c, c, 1'b0});
      rd(ADDR_IO_CTRL, v);
    end
    wr(ADDR_IO_CTRL, 8'h72);
    chk({7'h0, forcedFixedFreq}, 8'h00);
  endtask
  task automatic t_sleep();
    wr(ADDR_IO_CTRL, 8'h0D);
    wr(ADDR_CORE_CTRL, 8'h9B);
    chk(rails(), 8'h61);
    chk({7'h0, vibratorOe}, 8'h01);
    slp(1'b1);
    chk(rails(), 8'h1A);
    slp(1'b0);
    chk(rails(), 8'h61);
    wr(ADDR_IO_CTRL, 8'h1D);
    wr(ADDR_CORE_CTRL, 8'h1B);
    slp(1'b1);
    chk(rails(), 8'h62);
    wr(ADDR_CORE_CTRL, 8'h9B);
    chk(rails(), 8'h4A);
    slp(1'b0);
    wr(ADDR_IO_CTRL, 8'h05);
    slp(1'b1);
    chk(rails(), 8'h61);
    slp(1'b0);
    wr(ADDR_CORE_CTRL, 8'h99);
    chk({7'h0, vibratorOe}, 8'h00);
  endtask
  task automatic t_regulators();
    logic [7:0] val[4] = '{8'h00, 8'hDA, 8'h12, 8'hBF};
    logic [7:0] nrm[4] = '{8'h00, 8'h9A, 8'h12, 8'hBB};
    logic [7:0] low[4] = '{8'h00, 8'h1E, 8'h12, 8'hF3};
    wr(ADDR_IO_CTRL, 8'h18);
    // Voltage fields follow every write, whether or not the enable bit is set in it
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_LREG_CTRL, val[i]);
      rd(ADDR_LREG_CTRL, val[i]);
      chk(regs(), nrm[i]);
      slp(1'b1);
      chk(regs(), low[i]);
      slp(1'b0);
    end
  endtask
  task automatic t_pins();
    logic [7:0] cfg[2] = '{8'h58, 8'hA7};
    logic [7:0] c;
    logic lvl;
    int cnt;
    for (int k = 0; k < 2; k++) begin
      c = cfg[k];
      wr(ADDR_PIN_CFG, c);
      for (int i = 0; i < 4; i++) begin
        for (int e = 0; e < 2; e++) begin
          lvl = (e == 0);
          cnt = 0;
          gpioPin[i] <= lvl;
          repeat (8) begin
            @(posedge clk);
            if (pinEvent[i] === 1'b1)
              cnt++;
          end
          chk(cnt[7:0], {7'h0, (c[4 + i] == lvl) & ~c[i]});
        end
      end
    end
  endtask
  initial begin
    rst = 1'b1;
    sleepRequestPin = 1'b0;
    ioRailDefaultPin = 1'b1;
    coreDefaultPin = 1'b0;
    gpioPin = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (10) @(posedge clk);
    t_reset();
    t_io_fields();
    t_sleep();
    t_regulators();
    t_pins();
    wrap_up();
  end
  // Whole run needs about 17k clk; give it over three times that
  initial begin
    repeat (60000) @(posedge clk);
    nMismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire
